// ### rtl/prq_pkg.sv
// Purpose: shared constants and carriers for the page request reporting block
// Assumes: 256-bit descriptors, one memory write port
// Notes: register offsets are byte addresses on axi4-lite
package prq_pkg;
  localparam int unsigned DESC_W = 256;
  localparam logic [7:0] DESC_TYPE_PAGE_REQ = 8'h01;
  // descriptor field positions
  localparam int unsigned F_TYPE_LO = 0;
  localparam int unsigned F_PASID_EN = 8;
  localparam int unsigned F_RD = 9;
  localparam int unsigned F_WR = 10;
  localparam int unsigned F_EXE = 11;
  localparam int unsigned F_PRIV = 12;
  localparam int unsigned F_LAST = 13;
  localparam int unsigned F_DATA_EN = 14;
  localparam int unsigned F_GROUP_LO = 16;
  localparam int unsigned F_RID_LO = 32;
  localparam int unsigned F_PASID_LO = 48;
  localparam int unsigned F_ADDR_LO = 76;
  localparam int unsigned F_PRIV_DATA_LO = 128;
  // register byte offsets
  localparam logic [7:0] OFS_HEAD = 8'h00;
  localparam logic [7:0] OFS_TAIL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVENT = 8'h0c;
  localparam logic [7:0] OFS_SIZE = 8'h10;
  localparam logic [7:0] OFS_BASE = 8'h14;
  // status and event control bit positions
  localparam int unsigned B_WAITING = 0;
  localparam int unsigned B_OVERFLOW = 1;
  localparam int unsigned B_HELD = 30;
  localparam int unsigned B_MASK = 31;
  localparam logic B_MASK_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [15:0] requester_id;
    logic pasid_en;
    logic [19:0] pasid;
    logic [51:0] page_addr;
    logic [8:0] group_index_field;
    logic group_last_flag;
    logic rd;
    logic wr;
    logic exe;
    logic priv;
    logic attached_data_flag;
    logic [127:0] priv_data;
  } page_req_t;
endpackage

// ### rtl/desc_format.sv
// Purpose: packs one page request message into a queue descriptor
// Assumes: message fields already decoded
// Notes: purely combinational
`timescale 1ns/1ps
module desc_format
(
  input wire prq_pkg::page_req_t req,
  output logic [prq_pkg::DESC_W-1:0] desc
);
  always_comb
  begin
    desc = '0;
    desc[prq_pkg::F_TYPE_LO +: 8] = prq_pkg::DESC_TYPE_PAGE_REQ;
    desc[prq_pkg::F_PASID_EN] = req.pasid_en;
    if (req.pasid_en)
    begin
      desc[prq_pkg::F_PASID_LO +: 20] = req.pasid;
    end
    desc[prq_pkg::F_RD] = req.rd;
    desc[prq_pkg::F_WR] = req.wr;
    // execute meaningful only with pasid and read
    desc[prq_pkg::F_EXE] = req.exe & req.pasid_en & req.rd;
    // privilege: 1 supervisor, 0 user
    desc[prq_pkg::F_PRIV] = req.priv & req.pasid_en
      & (req.rd | req.wr);
    desc[prq_pkg::F_LAST] = req.group_last_flag;
    desc[prq_pkg::F_RID_LO +: 16] = req.requester_id;
    if (req.rd | req.wr)
    begin
      desc[prq_pkg::F_ADDR_LO +: 52] = req.page_addr;
    end
    desc[prq_pkg::F_GROUP_LO +: 9] = req.group_index_field;
    desc[prq_pkg::F_DATA_EN] = req.attached_data_flag;
    if (req.attached_data_flag)
    begin
      desc[prq_pkg::F_PRIV_DATA_LO +: 128] = req.priv_data;
    end
  end
endmodule

// ### rtl/page_request_report_event.sv
// Purpose: writes page request descriptors to a memory queue and raises
//   the recoverable fault event
// Assumes: memory write port acknowledges once the write is visible
// Notes: axi4-lite register slave, one outstanding descriptor write
// Functional notes
// - descriptor carries the 9-bit group index from the message
// - pasid present flag is 1 with pasid, 0 without
// - pasid field filled only when pasid present
// - address filled when read or write requested, else reserved
// - last-in-group flag copied when message ends its page group
// - read and write requested flags copied from the fault
// - execute flag meaningful only with pasid and read set
// - privilege 1 supervisor, 0 user, meaningful with pasid and access
// - attached data flag is 1 with 128 data bits, 0 without
// - private data ignored when no data attached
// - each queued descriptor sets the request waiting flag
// - write finding queue full sets the overflow flag
// - no new event if waiting or overflow already set
// - else set held flag; unmasked sends and clears it
// - clearing mask while held sends interrupt and clears held
// - clearing both status flags while held clears held silently
// - interrupt only after all descriptor writes visible and tail moved
// - tail read completes only after descriptor writes visible
// - status, tail, event reads wait for in-flight interrupt push
// - event interrupt sent directly, never remapped
// - descriptor is 256 bits with type code in bits 7:0
// - tail advances only after write visibility confirmed
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module page_request_report_event
#(
  parameter int unsigned PTR_W = 16
)
(
  input wire logic clk,
  input wire logic srst,
  // incoming page request message
  input wire logic req_valid,
  output logic req_ready,
  input wire prq_pkg::page_req_t req,
  // descriptor write to memory
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [63:0] mem_addr,
  output logic [prq_pkg::DESC_W-1:0] mem_data,
  input wire logic mem_visible,
  // direct event interrupt message
  output logic irq_valid,
  input wire logic irq_done,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_ISSUE = 3'b010,
    W_WAIT = 3'b100
  } wr_state_t;

  typedef struct packed {
    wr_state_t wst;
    logic [prq_pkg::DESC_W-1:0] desc;
    logic [PTR_W-1:0] head;
    logic [PTR_W-1:0] queue_tail_pointer;
    logic [PTR_W-1:0] size;
    logic [63:0] base;
    logic request_waiting_flag;
    logic queue_overflow_flag;
    logic interrupt_held_flag;
    logic event_mask_bit;
    logic irq_pend;
    logic irq_busy;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic ar_have;
    logic [7:0] ar_addr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t q;
  state_t next_q;
  logic [prq_pkg::DESC_W-1:0] fmt_desc;

  // ==========================================================
  // helpers
  function automatic logic [PTR_W-1:0] ptr_inc(
    input logic [PTR_W-1:0] p,
    input logic [PTR_W-1:0] n
  );
    logic [PTR_W-1:0] r;
    r = p + {{(PTR_W-1){1'b0}}, 1'b1};
    if (r >= n)
    begin
      r = '0;
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] st
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  desc_format u_fmt
  (
    .req(req),
    .desc(fmt_desc)
  );

  // ==========================================================
  // derived terms
  logic queue_full;
  logic writes_idle;
  logic wr_go;
  logic rd_go;
  logic [31:0] wr_old;
  logic [31:0] wr_new;
  logic set_waiting;
  logic set_overflow;
  logic fire_event;

  assign queue_full = (ptr_inc(q.queue_tail_pointer, q.size) == q.head);
  assign writes_idle = (q.wst == W_IDLE);
  assign req_ready = writes_idle;
  assign wr_go = q.aw_have && q.w_have && !q.bvalid;
  // status/tail/event reads wait for pushed interrupt; tail read waits
  // for every descriptor write to be visible
  assign rd_go = q.ar_have && !q.rvalid && !q.irq_pend && !q.irq_busy
    && (writes_idle || q.ar_addr != prq_pkg::OFS_TAIL);
  assign set_waiting = (q.wst == W_WAIT) && mem_visible;
  assign set_overflow = req_valid && req_ready && queue_full;

  always_comb
  begin
    wr_old = 32'h0000_0000;
    case (q.aw_addr)
      prq_pkg::OFS_HEAD: wr_old = 32'(q.head);
      prq_pkg::OFS_SIZE: wr_old = 32'(q.size);
      prq_pkg::OFS_BASE: wr_old = q.base[31:0];
      default: wr_old = 32'h0000_0000;
    endcase
    wr_new = merge(wr_old, q.w_data, q.w_strb);
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_q = q;
    fire_event = 1'b0;
    // descriptor write sequence
    case (q.wst)
      W_IDLE:
      begin
        if (req_valid && !queue_full)
        begin
          next_q.desc = fmt_desc;
          next_q.wst = W_ISSUE;
        end
      end
      W_ISSUE:
      begin
        if (mem_ready)
        begin
          next_q.wst = W_WAIT;
        end
      end
      W_WAIT:
      begin
        if (mem_visible)
        begin
          next_q.queue_tail_pointer =
            ptr_inc(q.queue_tail_pointer, q.size);
          next_q.wst = W_IDLE;
        end
      end
      default: next_q.wst = W_IDLE;
    endcase
    // event generation, evaluated on old status
    if ((set_waiting || set_overflow)
      && !q.request_waiting_flag && !q.queue_overflow_flag)
    begin
      if (q.event_mask_bit)
      begin
        next_q.interrupt_held_flag = 1'b1;
      end
      else
      begin
        fire_event = 1'b1;
      end
    end
    // axi capture
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_q.aw_have = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_q.w_have = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_q.ar_have = 1'b1;
      next_q.ar_addr = s_axi_araddr;
    end
    if (q.bvalid && s_axi_bready)
    begin
      next_q.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready)
    begin
      next_q.rvalid = 1'b0;
    end
    // register writes
    if (wr_go)
    begin
      next_q.aw_have = 1'b0;
      next_q.w_have = 1'b0;
      next_q.bvalid = 1'b1;
      case (q.aw_addr)
        prq_pkg::OFS_HEAD: next_q.head = wr_new[PTR_W-1:0];
        prq_pkg::OFS_SIZE: next_q.size = wr_new[PTR_W-1:0];
        prq_pkg::OFS_BASE: next_q.base = {32'h0000_0000, wr_new};
        prq_pkg::OFS_STATUS:
        begin
          // write one to clear
          if (q.w_strb[0] && q.w_data[prq_pkg::B_WAITING])
          begin
            next_q.request_waiting_flag = 1'b0;
          end
          if (q.w_strb[0] && q.w_data[prq_pkg::B_OVERFLOW])
          begin
            next_q.queue_overflow_flag = 1'b0;
          end
        end
        prq_pkg::OFS_EVENT:
        begin
          if (q.w_strb[3])
          begin
            next_q.event_mask_bit = q.w_data[prq_pkg::B_MASK];
            if (!q.w_data[prq_pkg::B_MASK] && q.interrupt_held_flag)
            begin
              next_q.interrupt_held_flag = 1'b0;
              fire_event = 1'b1;
            end
          end
        end
        default: next_q.bvalid = 1'b1;
      endcase
    end
    // hardware set wins over software clear
    if (set_waiting)
    begin
      next_q.request_waiting_flag = 1'b1;
    end
    if (set_overflow)
    begin
      next_q.queue_overflow_flag = 1'b1;
    end
    // both serviced while held: drop silently
    if (q.interrupt_held_flag && !next_q.request_waiting_flag
      && !next_q.queue_overflow_flag && !fire_event)
    begin
      next_q.interrupt_held_flag = 1'b0;
    end
    // interrupt waits for all descriptor writes visible and tail moved
    if (q.irq_pend && !q.irq_busy && writes_idle)
    begin
      next_q.irq_pend = 1'b0;
      next_q.irq_busy = 1'b1;
    end
    if (fire_event)
    begin
      next_q.irq_pend = 1'b1;
    end
    if (q.irq_busy && irq_done)
    begin
      next_q.irq_busy = 1'b0;
    end
    // register reads
    if (rd_go)
    begin
      next_q.ar_have = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = prq_pkg::RESP_OKAY;
      next_q.rdata = 32'h0000_0000;
      case (q.ar_addr)
        prq_pkg::OFS_HEAD: next_q.rdata = 32'(q.head);
        prq_pkg::OFS_TAIL: next_q.rdata = 32'(q.queue_tail_pointer);
        prq_pkg::OFS_SIZE: next_q.rdata = 32'(q.size);
        prq_pkg::OFS_BASE: next_q.rdata = q.base[31:0];
        prq_pkg::OFS_STATUS:
        begin
          next_q.rdata[prq_pkg::B_WAITING] = q.request_waiting_flag;
          next_q.rdata[prq_pkg::B_OVERFLOW] = q.queue_overflow_flag;
        end
        prq_pkg::OFS_EVENT:
        begin
          next_q.rdata[prq_pkg::B_MASK] = q.event_mask_bit;
          next_q.rdata[prq_pkg::B_HELD] = q.interrupt_held_flag;
        end
        default: next_q.rresp = prq_pkg::RESP_SLVERR;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q <= '0;
      q.wst <= W_IDLE;
      q.size <= '1;
      q.event_mask_bit <= prq_pkg::B_MASK_RESET;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs
  assign mem_valid = (q.wst == W_ISSUE);
  assign mem_data = q.desc;
  assign mem_addr = q.base + {{(64-PTR_W-5){1'b0}}, q.queue_tail_pointer,
    5'b00000};
  // event message goes straight out, not through remapping
  assign irq_valid = q.irq_busy;
  assign s_axi_awready = !q.aw_have;
  assign s_axi_wready = !q.w_have;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = prq_pkg::RESP_OKAY;
  assign s_axi_arready = !q.ar_have;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // ==========================================================
  // checks
  property p_tail_visible;
    @(posedge clk) disable iff (srst)
    (q.queue_tail_pointer != $past(q.queue_tail_pointer))
      |-> $past(q.wst == W_WAIT && mem_visible);
  endproperty
  a_tail_visible: assert property (p_tail_visible)
    else $error("tail moved without visible write");

  property p_irq_after_write;
    @(posedge clk) disable iff (srst)
    $rose(irq_valid) |-> $past(q.wst == W_IDLE);
  endproperty
  a_irq_after_write: assert property (p_irq_after_write)
    else $error("interrupt before descriptor visible");

  property p_tail_read;
    @(posedge clk) disable iff (srst)
    $rose(s_axi_rvalid) && $past(q.ar_addr == prq_pkg::OFS_TAIL)
      |-> $past(q.wst == W_IDLE);
  endproperty
  a_tail_read: assert property (p_tail_read)
    else $error("tail read with write in flight");

  property p_read_push;
    @(posedge clk) disable iff (srst)
    $rose(s_axi_rvalid) |-> $past(!q.irq_pend && !q.irq_busy);
  endproperty
  a_read_push: assert property (p_read_push)
    else $error("read completed with interrupt in flight");

  property p_waiting_set;
    @(posedge clk) disable iff (srst)
    set_waiting |=> q.request_waiting_flag;
  endproperty
  a_waiting_set: assert property (p_waiting_set)
    else $error("waiting flag not set");

  property p_overflow_set;
    @(posedge clk) disable iff (srst)
    (req_valid && writes_idle && queue_full)
      |=> q.queue_overflow_flag && q.wst == W_IDLE;
  endproperty
  a_overflow_set: assert property (p_overflow_set)
    else $error("overflow not flagged");

  property p_no_event;
    @(posedge clk) disable iff (srst)
    (set_waiting && (q.request_waiting_flag || q.queue_overflow_flag)
      && !wr_go) |=> $stable(q.irq_pend)
      && $stable(q.interrupt_held_flag);
  endproperty
  a_no_event: assert property (p_no_event)
    else $error("event from already set status");

  property p_masked_hold;
    @(posedge clk) disable iff (srst)
    (set_waiting && !q.request_waiting_flag && !q.queue_overflow_flag
      && q.event_mask_bit && !wr_go)
      |=> q.interrupt_held_flag && $stable(q.irq_pend);
  endproperty
  a_masked_hold: assert property (p_masked_hold)
    else $error("masked event not held");

  property p_type_code;
    @(posedge clk) disable iff (srst)
    mem_valid |-> mem_data[7:0] == prq_pkg::DESC_TYPE_PAGE_REQ;
  endproperty
  a_type_code: assert property (p_type_code)
    else $error("bad descriptor type");

  c_desc: cover property (@(posedge clk) disable iff (srst)
    set_waiting ##[1:20] irq_valid);
  c_overflow: cover property (@(posedge clk) disable iff (srst)
    set_overflow);
  c_unmask: cover property (@(posedge clk) disable iff (srst)
    q.interrupt_held_flag ##[1:50] irq_valid);
endmodule

// ### verification/prq_far_end.sv
// Purpose: memory and interrupt sink seen by the page request block
// Assumes: one descriptor write outstanding at a time
// Notes: visibility and commit delays are set by the bench
`timescale 1ns/1ps
module prq_far_end
(
  input wire logic clk,
  input wire logic srst,
  input wire logic mem_valid,
  output logic mem_ready,
  input wire logic [prq_pkg::DESC_W-1:0] mem_data,
  output logic mem_visible,
  input wire logic irq_valid,
  output logic irq_done,
  input wire logic [3:0] vis_delay,
  input wire logic [3:0] irq_delay,
  output logic [prq_pkg::DESC_W-1:0] last_desc,
  output logic write_open,
  output int desc_count,
  output int irq_count
);
  logic [3:0] vcnt;
  logic [3:0] icnt;
  // ==================================================================
  // memory: take one descriptor, confirm visibility after vis_delay
  always @(posedge clk)
  begin
    if (srst)
    begin
      mem_ready <= 1'b0;
      mem_visible <= 1'b0;
      write_open <= 1'b0;
      desc_count <= 0;
      vcnt <= 4'h0;
    end
    else
    begin
      mem_ready <= mem_valid && !mem_ready && !write_open;
      mem_visible <= 1'b0;
      if (mem_valid && mem_ready)
      begin
        last_desc <= mem_data;
        write_open <= 1'b1;
        vcnt <= vis_delay;
        desc_count <= desc_count + 1;
      end
      else if (write_open && mem_visible)
        write_open <= 1'b0;
      else if (write_open && vcnt == 4'h0)
        mem_visible <= 1'b1;
      else if (write_open)
        vcnt <= vcnt - 4'h1;
    end
  end
  // ==================================================================
  // interrupt sink: commit after irq_delay cycles
  always @(posedge clk)
  begin
    if (srst)
    begin
      irq_done <= 1'b0;
      icnt <= 4'h0;
      irq_count <= 0;
    end
    else
    begin
      irq_done <= 1'b0;
      if (irq_valid && !irq_done && icnt == irq_delay)
      begin
        irq_done <= 1'b1;
        icnt <= 4'h0;
        irq_count <= irq_count + 1;
      end
      else if (irq_valid && !irq_done)
        icnt <= icnt + 4'h1;
    end
  end
endmodule

// ### verification/testbench.sv
// Purpose: self-checking bench for page_request_report_event
// Assumes: far end modelled by prq_far_end
// Notes: queue of 4 entries at byte base 0x1000
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  prq_pkg::page_req_t req = '0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [3:0] vis_delay = 4'h2;
  logic [3:0] irq_delay = 4'h1;
  logic req_ready, mem_valid, mem_ready, mem_visible, irq_valid, irq_done;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, write_open;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [255:0] mem_data, last_desc;
  logic [63:0] mem_addr, last_addr;
  prq_pkg::page_req_t r;
  int desc_count, irq_count, miscompares, total_checks, n;
  always #2.5 clk = ~clk;
  page_request_report_event dut_u (.clk(clk), .srst(srst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_visible(mem_visible),
    .irq_valid(irq_valid), .irq_done(irq_done),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  prq_far_end far_u (.clk(clk), .srst(srst), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_data(mem_data),
    .mem_visible(mem_visible), .irq_valid(irq_valid),
    .irq_done(irq_done), .vis_delay(vis_delay), .irq_delay(irq_delay),
    .last_desc(last_desc), .write_open(write_open),
    .desc_count(desc_count), .irq_count(irq_count));
  always @(posedge clk)
    if (mem_valid && mem_ready)
      last_addr <= mem_addr;
  // ==================================================================
  // helpers
  task automatic check(input string what, input logic [127:0] e,
    input logic [127:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %0h seen %0h", what, e, g);
      miscompares++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w) && n < 100)
    begin
      @(posedge clk);
      n++;
      if (!aw && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (!w && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      aw = aw || s_axi_awready;
      w = w || s_axi_wready;
    end
    do
    begin
      @(posedge clk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    s_axi_wdata <= ~d;
    check("bvalid", 1'b1, s_axi_bvalid);
    check("bresp", prq_pkg::RESP_OKAY, s_axi_bresp);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 100);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do
    begin
      @(posedge clk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check("rvalid", 1'b1, s_axi_rvalid);
  endtask
  function automatic prq_pkg::page_req_t mk(input logic pe,
    input logic [8:0] g, input logic [5:0] f);
    prq_pkg::page_req_t q;
    q.requester_id = {7'h2b, g};
    q.pasid_en = pe;
    q.pasid = {11'h5a5, g};
    q.page_addr = {43'h123_4567_89ab, g};
    q.group_index_field = g;
    {q.group_last_flag, q.rd, q.wr, q.exe, q.priv,
      q.attached_data_flag} = f;
    q.priv_data = {4{16'hc3a5, 7'h00, g}};
    return q;
  endfunction
  // each last-in-group request uses its own group index
  task automatic send_req(input prq_pkg::page_req_t q);
    @(posedge clk);
    req <= q;
    req_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    check("req_taken", 1'b1, req_ready);
    req_valid <= 1'b0;
    req <= ~q;
  endtask
  task automatic wait_idle();
    @(posedge clk);
    n = 0;
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    check("req_ready", 1'b1, req_ready);
  endtask
  task automatic chk_desc(input prq_pkg::page_req_t q);
    logic [255:0] d;
    d = last_desc;
    check("type", prq_pkg::DESC_TYPE_PAGE_REQ, d[7:0]);
    check("pasid_en", q.pasid_en, d[prq_pkg::F_PASID_EN]);
    if (q.pasid_en)
      check("pasid", q.pasid, d[prq_pkg::F_PASID_LO+:20]);
    if (q.rd || q.wr)
      check("addr", q.page_addr, d[prq_pkg::F_ADDR_LO+:52]);
    check("group", q.group_index_field, d[prq_pkg::F_GROUP_LO+:9]);
    check("last", q.group_last_flag, d[prq_pkg::F_LAST]);
    check("rw", {q.wr, q.rd}, {d[prq_pkg::F_WR], d[prq_pkg::F_RD]});
    if (q.pasid_en && q.rd)
      check("exe", q.exe, d[prq_pkg::F_EXE]);
    if (q.pasid_en && (q.rd || q.wr))
      check("priv", q.priv, d[prq_pkg::F_PRIV]);
    check("data_en", q.attached_data_flag, d[prq_pkg::F_DATA_EN]);
    if (q.attached_data_flag)
      check("pdata", q.priv_data, d[prq_pkg::F_PRIV_DATA_LO+:128]);
  endtask
  // ==================================================================
  // scenarios
  task automatic t_fields();
    logic [15:0] tbl [3];
    tbl = '{16'hf7ff, 16'h0930, 16'h12a8};
    axi_wr(prq_pkg::OFS_BASE, 32'h0000_1000, 4'hf);
    axi_wr(prq_pkg::OFS_SIZE, 32'h0000_0004, 4'hf);
    foreach (tbl[i])
    begin
      r = mk(tbl[i][12], tbl[i][8:0], {tbl[i][14:13], tbl[i][11:9],
        tbl[i][15]});
      send_req(r);
      wait_idle();
      chk_desc(r);
      check("mem_addr", 32'h0000_1000 + 32 * i, last_addr);
    end
    axi_rd(prq_pkg::OFS_EVENT);
    check("held", 1'b1, rd[prq_pkg::B_HELD]);
    check("irqs", 0, irq_count);
  endtask
  task automatic t_full();
    send_req(mk(1'b0, 9'h055, 6'b010000));
    wait_idle();
    check("descs", 3, desc_count);
    axi_rd(prq_pkg::OFS_STATUS);
    check("status", 2'b11, rd[1:0]);
    axi_rd(prq_pkg::OFS_TAIL);
    check("tail", 3, rd);
  endtask
  task automatic t_unmask();
    irq_delay <= 4'h6;
    axi_wr(prq_pkg::OFS_EVENT, 32'h0000_0000, 4'b1000);
    axi_rd(prq_pkg::OFS_STATUS);
    check("irqs", 1, irq_count);
    axi_rd(prq_pkg::OFS_EVENT);
    check("held", 1'b0, rd[prq_pkg::B_HELD]);
    axi_wr(prq_pkg::OFS_HEAD, 32'h0000_0003, 4'hf);
    send_req(mk(1'b1, 9'h100, 6'b101000));
    wait_idle();
    repeat (12) @(posedge clk);
    check("irqs", 1, irq_count);
  endtask
  task automatic t_unmasked();
    axi_wr(prq_pkg::OFS_STATUS, 32'h0000_0003, 4'hf);
    vis_delay <= 4'h9;
    fork
      send_req(mk(1'b1, 9'h0f0, 6'b110110));
      begin
        wait (write_open === 1'b1);
        axi_rd(prq_pkg::OFS_TAIL);
        check("tail", 1, rd);
      end
      begin
        wait (irq_valid === 1'b1);
        check("open", 1'b0, write_open);
      end
    join
    wait_idle();
    axi_rd(prq_pkg::OFS_EVENT);
    check("irqs", 2, irq_count);
    check("held", 1'b0, rd[prq_pkg::B_HELD]);
  endtask
  task automatic t_silent();
    axi_wr(prq_pkg::OFS_EVENT, 32'h8000_0000, 4'b1000);
    axi_wr(prq_pkg::OFS_STATUS, 32'h0000_0003, 4'hf);
    send_req(mk(1'b0, 9'h1a0, 6'b011000));
    wait_idle();
    axi_rd(prq_pkg::OFS_EVENT);
    check("held", 1'b1, rd[prq_pkg::B_HELD]);
    axi_wr(prq_pkg::OFS_STATUS, 32'h0000_0003, 4'hf);
    axi_rd(prq_pkg::OFS_EVENT);
    check("held", 1'b0, rd[prq_pkg::B_HELD]);
    axi_wr(prq_pkg::OFS_EVENT, 32'h0000_0000, 4'b1000);
    repeat (12) @(posedge clk);
    check("irqs", 2, irq_count);
    axi_rd(8'h20);
    check("resp", prq_pkg::RESP_SLVERR, rs);
  endtask
  // ==================================================================
  // main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    axi_rd(prq_pkg::OFS_EVENT);
    check("mask", prq_pkg::B_MASK_RESET, rd[prq_pkg::B_MASK]);
    t_fields();
    t_full();
    t_unmask();
    t_unmasked();
    t_silent();
    complete_run();
  end
  initial
  begin
    #50000;
    miscompares++;
    complete_run();
  end
endmodule
